//--- hw/tlip_pkg.sv
package tlip_pkg;

  // Register byte addresses, one aligned word each
  localparam logic [11:0] CTRL0_OFF = 12'h000;
  localparam logic [11:0] CTRL2_OFF = 12'h004;
  localparam logic [11:0] CTRL3_OFF = 12'h008;
  localparam logic [11:0] PFLAG1_OFF = 12'h00C;
  localparam logic [11:0] PEN1_OFF = 12'h018;
  localparam logic [11:0] PPRI1_OFF = 12'h024;
  localparam logic [11:0] RSTCTL_OFF = 12'h030;
  localparam logic [11:0] REG_STRIDE = 12'h004;

  // General control register 0 fields
  localparam int GH_BIT = 7;
  localparam int PL_BIT = 6;
  localparam int TMR_EN_BIT = 5;
  localparam int EXT0_EN_BIT = 4;
  localparam int CHG_EN_BIT = 3;
  localparam int TMR_FLG_BIT = 2;
  localparam int EXT0_FLG_BIT = 1;
  localparam int CHG_FLG_BIT = 0;

  // General control register 2 fields
  localparam int EDGE0_BIT = 6;
  localparam int EDGE1_BIT = 5;
  localparam int EDGE2_BIT = 4;
  localparam int TMR_PRI_BIT = 2;
  localparam int CHG_PRI_BIT = 0;

  // General control register 3 fields
  localparam int EXT2_PRI_BIT = 7;
  localparam int EXT1_PRI_BIT = 6;
  localparam int EXT2_EN_BIT = 4;
  localparam int EXT1_EN_BIT = 3;
  localparam int EXT2_FLG_BIT = 1;
  localparam int EXT1_FLG_BIT = 0;

  // Reset control register field
  localparam int PME_BIT = 7;

  // Implemented-bit masks and reset values
  localparam logic [7:0] CTRL2_MASK = 8'h75;
  localparam logic [7:0] CTRL3_MASK = 8'hDB;
  localparam logic [7:0] RSTCTL_MASK = 8'h80;
  localparam logic [7:0] CTRL0_RST = 8'h00;
  localparam logic [7:0] CTRL2_RST = 8'h75;
  localparam logic [7:0] CTRL3_RST = 8'hC0;
  localparam logic [7:0] PEN_RST = 8'h00;
  localparam logic [7:0] PPRI_RST = 8'hFF;
  localparam logic [7:0] RSTCTL_RST = 8'h00;

  // Service vectors
  localparam logic [15:0] HI_VEC = 16'h0008;
  localparam logic [15:0] LO_VEC = 16'h0018;

  typedef enum logic [1:0] {SVC_IDLE, SVC_LO, SVC_HI, SVC_HI_OVER_LO} tlip_svc_e;

endpackage

//--- hw/tlip_edge_sync.sv
`timescale 1ns/100ps
`default_nettype none

module tlip_edge_sync
(
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic pin_i,
  input wire logic rising_sel_i,
  output logic evt_o
);

  logic sync1_q;
  logic sync2_q;
  logic prev_q;

  // Two-stage synchroniser, then one more stage for the edge compare
  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
    begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q <= 1'b0;
    end
    else
    begin
      sync1_q <= pin_i;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  // Edge of the selected polarity, one cycle wide
  assign evt_o = rising_sel_i ? (sync2_q & ~prev_q) : (~sync2_q & prev_q);

endmodule

`default_nettype wire

//--- hw/tlip_flag_bank.sv
`timescale 1ns/100ps
`default_nettype none

module tlip_flag_bank
#(
  parameter int WIDTH = 8
)
(
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic [WIDTH-1:0] set_i,
  input wire logic wr_i,
  input wire logic [WIDTH-1:0] wdata_i,
  output logic [WIDTH-1:0] flag_o
);

  logic [WIDTH-1:0] flag_q;
  logic [WIDTH-1:0] flag_d;

  // Software write loads the flags, but a new event always wins
  assign flag_d = (wr_i ? wdata_i : flag_q) | set_i;

  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
      flag_q <= '0;
    else
      flag_q <= flag_d;
  end

  assign flag_o = flag_q;

endmodule

`default_nettype wire

//--- hw/tlip_irq_ctrl.sv
// What this block does
// R1: External line zero is always high priority
// R2: High vector 0008h, low vector 0018h
// R3: High request preempts running low service
// R4: Each source has flag, enable, priority
// R5: Mode bit resets to compatibility; priorities ignored
// R6: Peripheral enable gates only peripheral sources
// R7: Global enable clear blocks every source
// R8: Compatibility mode always vectors to 0008h
// R9: High enable allows high, clear blocks all
// R10: Low enable gates low sources, needs high
// R11: Flag, enable, global enable together dispatch
// R12: Dispatch clears the applicable global enable
// R13: No low dispatch during high service
// R14: Core pushes return address, loads vector
// R15: Return sets the enable cleared on entry; a return in the same cycle as a high entry during low service is ignored
// R16: Pin event to dispatch three-four cycles
// R17: Flags set regardless of any enable
// R18: Software clears serviced flags before re-enabling
// R19: No memory-to-memory move on live registers
// R20: Thirteen registers govern the controller
// R21: Enables at bits 7, 6, reset zero
// R22: Pins synchronised; evaluation once per instruction
//
// Decided for this implementation: the address map and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none

module tlip_irq_ctrl
#(
  parameter int NUM_PREG = 3,
  parameter int ADDR_W = 12
)
(
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [2:0] ext_line_i,
  input wire logic port_change_i,
  input wire logic timer_ovf_i,
  input wire logic [8*NUM_PREG-1:0] periph_evt_i,
  input wire logic instr_boundary_i,
  input wire logic return_from_service_instr_i,
  output logic dispatch_o,
  output logic [15:0] vector_o,
  output logic hi_service_o,
  output logic lo_service_o
);

  // Register map holds exactly this many peripheral groups
  if (NUM_PREG != 3)
    $error("tlip_irq_ctrl: NUM_PREG must be 3");
  if (ADDR_W < 6 || ADDR_W > 12)
    $error("tlip_irq_ctrl: ADDR_W must lie in 6..12");

  logic [11:0] addr;
  logic wr_en;
  logic rd_setup;
  logic sel_ctrl0;
  logic sel_ctrl2;
  logic sel_ctrl3;
  logic sel_rstctl;
  logic [NUM_PREG-1:0] sel_pflag;
  logic [NUM_PREG-1:0] sel_pen;
  logic [NUM_PREG-1:0] sel_ppri;
  logic mapped;

  // Address decode; wider buses beyond 12 bits are refused at elaboration
  assign addr = 12'(paddr_i);
  assign wr_en = psel_i & penable_i & pwrite_i;
  assign rd_setup = psel_i & ~penable_i & ~pwrite_i;
  assign sel_ctrl0 = (addr == tlip_pkg::CTRL0_OFF);
  assign sel_ctrl2 = (addr == tlip_pkg::CTRL2_OFF);
  assign sel_ctrl3 = (addr == tlip_pkg::CTRL3_OFF);
  assign sel_rstctl = (addr == tlip_pkg::RSTCTL_OFF);

  for (genvar g = 0; g < NUM_PREG; g++)
  begin : g_dec
    assign sel_pflag[g] = (addr == tlip_pkg::PFLAG1_OFF + 12'(g) * tlip_pkg::REG_STRIDE);
    assign sel_pen[g] = (addr == tlip_pkg::PEN1_OFF + 12'(g) * tlip_pkg::REG_STRIDE);
    assign sel_ppri[g] = (addr == tlip_pkg::PPRI1_OFF + 12'(g) * tlip_pkg::REG_STRIDE);
  end

  // Thirteen registers in all; anything else answers with an error
  assign mapped = sel_ctrl0 | sel_ctrl2 | sel_ctrl3 | sel_rstctl
                | (|sel_pflag) | (|sel_pen) | (|sel_ppri); // see R20

  // Stored control state
  logic gh_q;
  logic gh_d;
  logic pl_q;
  logic pl_d;
  logic [2:0] core_en_q;
  logic [7:0] ctrl2_q;
  logic [7:0] ctrl3_q;
  logic [7:0] rstctl_q;
  logic [NUM_PREG-1:0][7:0] pen_q;
  logic [NUM_PREG-1:0][7:0] ppri_q;
  logic pme;

  assign pme = rstctl_q[tlip_pkg::PME_BIT];

  // Event capture: pins synchronised, internal events already in this domain
  logic [2:0] ext_evt;
  logic chg_evt;
  logic [2:0] edge_sel;

  assign edge_sel = {ctrl2_q[tlip_pkg::EDGE2_BIT], ctrl2_q[tlip_pkg::EDGE1_BIT],
                     ctrl2_q[tlip_pkg::EDGE0_BIT]};

  for (genvar g = 0; g < 3; g++)
  begin : g_ext
    tlip_edge_sync u_ext_sync
    (
      .ref_clk_i(ref_clk_i),
      .rstn_i(rstn_i),
      .pin_i(ext_line_i[g]),
      .rising_sel_i(edge_sel[g]),
      .evt_o(ext_evt[g])
    ); // see R22
  end

  // Port-change mismatch is a level; each new mismatch raises the flag
  tlip_edge_sync u_chg_sync
  (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .pin_i(port_change_i),
    .rising_sel_i(1'b1),
    .evt_o(chg_evt)
  ); // see R22

  // Flag banks; set by events with no regard to enables
  logic [2:0] core0_flag;
  logic [1:0] core3_flag;
  logic [NUM_PREG-1:0][7:0] pflag;
  logic [2:0] core0_set;
  logic [1:0] core3_set;

  assign core0_set = {timer_ovf_i, ext_evt[0], chg_evt}; // see R17
  assign core3_set = {ext_evt[2], ext_evt[1]}; // see R17

  tlip_flag_bank #(.WIDTH(3)) u_core0_flags
  (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .set_i(core0_set),
    .wr_i(wr_en & sel_ctrl0),
    .wdata_i(pwdata_i[tlip_pkg::TMR_FLG_BIT:tlip_pkg::CHG_FLG_BIT]),
    .flag_o(core0_flag)
  ); // see R4

  tlip_flag_bank #(.WIDTH(2)) u_core3_flags
  (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .set_i(core3_set),
    .wr_i(wr_en & sel_ctrl3),
    .wdata_i(pwdata_i[tlip_pkg::EXT2_FLG_BIT:tlip_pkg::EXT1_FLG_BIT]),
    .flag_o(core3_flag)
  ); // see R4

  for (genvar g = 0; g < NUM_PREG; g++)
  begin : g_pflag
    tlip_flag_bank #(.WIDTH(8)) u_pflags
    (
      .ref_clk_i(ref_clk_i),
      .rstn_i(rstn_i),
      .set_i(periph_evt_i[8*g +: 8]),
      .wr_i(wr_en & sel_pflag[g]),
      .wdata_i(pwdata_i[7:0]),
      .flag_o(pflag[g])
    ); // see R17
  end

  // Per-source view: flag, enable and priority for the five core sources and the peripheral groups
  logic [4:0] core_flag;
  logic [4:0] core_en;
  logic [4:0] core_pri;
  logic [8*NUM_PREG-1:0] p_flag;
  logic [8*NUM_PREG-1:0] p_en;
  logic [8*NUM_PREG-1:0] p_pri;

  // Order: ext2, ext1, timer, ext0, port change
  assign core_flag = {core3_flag, core0_flag};
  assign core_en = {ctrl3_q[tlip_pkg::EXT2_EN_BIT], ctrl3_q[tlip_pkg::EXT1_EN_BIT], core_en_q};
  assign core_pri = {ctrl3_q[tlip_pkg::EXT2_PRI_BIT], ctrl3_q[tlip_pkg::EXT1_PRI_BIT],
                     ctrl2_q[tlip_pkg::TMR_PRI_BIT], 1'b1,
                     ctrl2_q[tlip_pkg::CHG_PRI_BIT]}; // see R1
  assign p_flag = pflag;
  assign p_en = pen_q;
  assign p_pri = ppri_q;

  // Request qualification per mode
  logic core_any;
  logic periph_any;
  logic compat_req;
  logic hi_src;
  logic lo_src;
  logic hi_req;
  logic lo_req;

  assign core_any = |(core_flag & core_en); // see R11
  assign periph_any = |(p_flag & p_en); // see R11
  assign compat_req = gh_q & (core_any | (pl_q & periph_any)); // see R6 R7
  assign hi_src = |(core_flag & core_en & core_pri) | |(p_flag & p_en & p_pri); // see R5
  assign lo_src = |(core_flag & core_en & ~core_pri) | |(p_flag & p_en & ~p_pri);
  assign hi_req = gh_q & hi_src; // see R9
  assign lo_req = gh_q & pl_q & lo_src; // see R10

  // Service state: which routines are in progress
  tlip_pkg::tlip_svc_e svc_q;
  tlip_pkg::tlip_svc_e svc_d;
  logic take_hi;
  logic take_lo;
  logic ret;
  logic hi_active;
  logic lo_active;

  assign hi_active = (svc_q == tlip_pkg::SVC_HI) | (svc_q == tlip_pkg::SVC_HI_OVER_LO);
  assign lo_active = (svc_q == tlip_pkg::SVC_LO) | (svc_q == tlip_pkg::SVC_HI_OVER_LO);

  // Sampled only at instruction boundaries, so an event that arrives during a
  // longer instruction waits until that instruction ends
  assign take_hi = instr_boundary_i & (pme ? hi_req & ~hi_active
                                           : compat_req & ~hi_active); // see R3 R16 R22
  assign take_lo = instr_boundary_i & pme & lo_req & ~hi_active & ~lo_active
                   & ~take_hi; // see R13
  assign ret = return_from_service_instr_i;

  // Compatibility mode uses the high-level slot for every service
  always_comb
  begin
    svc_d = svc_q;
    case (svc_q)
      tlip_pkg::SVC_IDLE:
        if (take_hi)
          svc_d = tlip_pkg::SVC_HI;
        else if (take_lo)
          svc_d = tlip_pkg::SVC_LO;
      tlip_pkg::SVC_LO:
        if (take_hi)
          svc_d = tlip_pkg::SVC_HI_OVER_LO; // see R3
        else if (ret)
          svc_d = tlip_pkg::SVC_IDLE;
      tlip_pkg::SVC_HI:
        if (ret)
          svc_d = tlip_pkg::SVC_IDLE;
      tlip_pkg::SVC_HI_OVER_LO:
        if (ret)
          svc_d = tlip_pkg::SVC_LO;
      default:
        svc_d = tlip_pkg::SVC_IDLE;
    endcase
  end

  // Global enables: hardware clear on entry and set on return win over a
  // same-cycle software write, so a dispatch is never left half-done
  always_comb
  begin
    gh_d = gh_q;
    pl_d = pl_q;
    if (wr_en & sel_ctrl0)
    begin
      gh_d = pwdata_i[tlip_pkg::GH_BIT];
      pl_d = pwdata_i[tlip_pkg::PL_BIT];
    end
    if (take_hi)
      gh_d = 1'b0; // see R12
    else if (take_lo)
      pl_d = 1'b0; // see R12
    else if (ret)
    begin
      if (!pme || hi_active)
        gh_d = 1'b1; // see R15
      else if (lo_active)
        pl_d = 1'b1; // see R15
    end
  end

  // Enable and service registers
  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
    begin
      gh_q <= tlip_pkg::CTRL0_RST[tlip_pkg::GH_BIT]; // see R21
      pl_q <= tlip_pkg::CTRL0_RST[tlip_pkg::PL_BIT]; // see R21
      svc_q <= tlip_pkg::SVC_IDLE;
    end
    else
    begin
      gh_q <= gh_d;
      pl_q <= pl_d;
      svc_q <= svc_d;
    end
  end

  // Plain software-written configuration registers
  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
    begin
      core_en_q <= tlip_pkg::CTRL0_RST[tlip_pkg::TMR_EN_BIT:tlip_pkg::CHG_EN_BIT];
      ctrl2_q <= tlip_pkg::CTRL2_RST;
      ctrl3_q <= tlip_pkg::CTRL3_RST;
      rstctl_q <= tlip_pkg::RSTCTL_RST; // see R5
    end
    else if (wr_en)
    begin
      if (sel_ctrl0)
        core_en_q <= pwdata_i[tlip_pkg::TMR_EN_BIT:tlip_pkg::CHG_EN_BIT];
      if (sel_ctrl2)
        ctrl2_q <= pwdata_i[7:0] & tlip_pkg::CTRL2_MASK;
      if (sel_ctrl3)
        ctrl3_q <= pwdata_i[7:0] & tlip_pkg::CTRL3_MASK;
      if (sel_rstctl)
        rstctl_q <= pwdata_i[7:0] & tlip_pkg::RSTCTL_MASK;
    end
  end

  // Peripheral enable and priority groups
  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
    begin
      pen_q <= {NUM_PREG{tlip_pkg::PEN_RST}};
      ppri_q <= {NUM_PREG{tlip_pkg::PPRI_RST}};
    end
    else
    begin
      for (int i = 0; i < NUM_PREG; i++)
      begin
        if (wr_en & sel_pen[i])
          pen_q[i] <= pwdata_i[7:0];
        if (wr_en & sel_ppri[i])
          ppri_q[i] <= pwdata_i[7:0];
      end
    end
  end

  // Read view assembled from live state
  logic [7:0] ctrl0_rd;
  logic [7:0] rd_byte;

  assign ctrl0_rd = {gh_q, pl_q, core_en_q, core0_flag};

  always_comb
  begin
    rd_byte = 8'h00;
    if (sel_ctrl0)
      rd_byte = ctrl0_rd;
    if (sel_ctrl2)
      rd_byte = ctrl2_q;
    if (sel_ctrl3)
      rd_byte = {ctrl3_q[7:2], core3_flag}; // Flags read from the flag bank, not from ctrl3_q bits 1:0
    if (sel_rstctl)
      rd_byte = rstctl_q;
    for (int i = 0; i < NUM_PREG; i++)
    begin
      if (sel_pflag[i])
        rd_byte = pflag[i];
      if (sel_pen[i])
        rd_byte = pen_q[i];
      if (sel_ppri[i])
        rd_byte = ppri_q[i];
    end
  end

  // Read data is captured in the setup cycle and stands through access
  logic [31:0] prdata_q;

  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
      prdata_q <= 32'h0000_0000;
    else if (rd_setup)
      prdata_q <= {24'h00_0000, rd_byte};
  end

  // Zero-wait slave; unmapped addresses raise the error response
  assign prdata_o = prdata_q;
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~mapped;

  // Dispatch strobe and vector to the core, which stacks the return address
  logic dispatch_q;
  logic [15:0] vector_q;

  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
    begin
      dispatch_q <= 1'b0;
      vector_q <= 16'h0000;
    end
    else
    begin
      dispatch_q <= take_hi | take_lo; // see R14
      if (take_hi)
        vector_q <= tlip_pkg::HI_VEC; // see R2 R8
      else if (take_lo)
        vector_q <= tlip_pkg::LO_VEC; // see R2
    end
  end

  assign dispatch_o = dispatch_q;
  assign vector_o = vector_q;
  assign hi_service_o = hi_active;
  assign lo_service_o = lo_active;

endmodule

`default_nettype wire

//--- dv/tlip_irq_ctrl_props.sv
`timescale 1ns/100ps
`default_nettype none

module tlip_irq_props
#(
  parameter int NUM_PREG = 3,
  parameter int ADDR_W = 12
)
(
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic [2:0] ext_line_i,
  input wire logic port_change_i,
  input wire logic timer_ovf_i,
  input wire logic [8*NUM_PREG-1:0] periph_evt_i,
  input wire logic instr_boundary_i,
  input wire logic return_from_service_instr_i,
  input wire logic dispatch_o,
  input wire logic [15:0] vector_o,
  input wire logic hi_service_o,
  input wire logic lo_service_o
);
  default clocking dc @(posedge ref_clk_i);
  endclocking
  default disable iff (!rstn_i);

  // Bus side: only thirteen words decode
  AST_SLVERR: assert property (psel_i && penable_i && paddr_i > 12'h030 |-> pslverr_o)
    else $error("unmapped access not refused");
  AST_RDHI: assert property (prdata_o[31:8] == 24'h00_0000)
    else $error("upper read data not zero");
  // Dispatch timing and vector choice
  // A high request may preempt a low entry on the very next cycle
  AST_PULSE: assert property (dispatch_o
    |=> !dispatch_o || (hi_service_o && lo_service_o))
    else $error("dispatch longer than one cycle");
  AST_BOUNDARY: assert property (dispatch_o |-> $past(instr_boundary_i))
    else $error("dispatch not taken at a boundary");
  AST_VEC_HI: assert property (dispatch_o
    |-> ((vector_o == tlip_pkg::HI_VEC) == hi_service_o))
    else $error("high vector and high service disagree");
  AST_VEC_LO: assert property (dispatch_o && vector_o == tlip_pkg::LO_VEC |-> lo_service_o)
    else $error("low vector without low service");
  AST_VEC_HOLD: assert property (!dispatch_o |-> $stable(vector_o))
    else $error("vector changed without dispatch");
  // Return sampled in the same cycle may legally free the slot
  AST_NO_DISP_HI: assert property (dispatch_o
    |-> $past(!hi_service_o || return_from_service_instr_i))
    else $error("dispatch during high service");
  AST_LO_IDLE: assert property (dispatch_o && vector_o == tlip_pkg::LO_VEC
    |-> $past(return_from_service_instr_i || !(hi_service_o || lo_service_o)))
    else $error("low dispatch while a service runs");
  AST_RET_LO: assert property (return_from_service_instr_i && lo_service_o
    && !hi_service_o |=> !lo_service_o || dispatch_o)
    else $error("low service not left on return");

  CV_HI: cover property (dispatch_o && vector_o == tlip_pkg::HI_VEC);
  CV_LO: cover property (dispatch_o && vector_o == tlip_pkg::LO_VEC);
  CV_NEST: cover property (dispatch_o && hi_service_o && lo_service_o);
endmodule

bind tlip_irq_ctrl tlip_irq_props #(.NUM_PREG(NUM_PREG), .ADDR_W(ADDR_W)) u_props (
  .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .paddr_i(paddr_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .ext_line_i(ext_line_i),
  .port_change_i(port_change_i), .timer_ovf_i(timer_ovf_i), .periph_evt_i(periph_evt_i),
  .instr_boundary_i(instr_boundary_i), .return_from_service_instr_i(return_from_service_instr_i),
  .dispatch_o(dispatch_o), .vector_o(vector_o), .hi_service_o(hi_service_o),
  .lo_service_o(lo_service_o));

`default_nettype wire

//--- dv/tlip_core_model.sv
`timescale 1ns/100ps
`default_nettype none

module tlip_core_model
(
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic ret_go_i,
  input wire logic dispatch_i,
  input wire logic [15:0] vector_i,
  output logic instr_boundary_o,
  output logic ret_o,
  output logic [1:0] depth_o,
  output logic [15:0] pc_o
);
  logic [15:0] stack_q [4];

  // One-cycle instructions; return only from inside a routine
  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
    begin
      instr_boundary_o <= 1'b0;
      ret_o <= 1'b0;
      depth_o <= 2'h0;
      pc_o <= 16'h0100;
    end
    else
    begin
      instr_boundary_o <= 1'b1;
      ret_o <= ret_go_i && (depth_o != 2'h0);
      if (dispatch_i)
      begin
        stack_q[depth_o] <= pc_o;
        pc_o <= vector_i;
        depth_o <= depth_o + 2'h1;
      end
      else if (ret_o)
      begin
        pc_o <= stack_q[depth_o - 2'h1];
        depth_o <= depth_o - 2'h1;
      end
      else
        pc_o <= pc_o + 16'h0001;
    end
  end
endmodule

`default_nettype wire

//--- dv/tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  logic ref_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, serr, bnd, ret, disp, hi, lo;
  logic [2:0] ext = 3'h0;
  logic tmr = 1'b0;
  logic chg = 1'b0;
  logic ret_go = 1'b0;
  logic [23:0] pev = 24'h00_0000;
  logic [15:0] vec, pc;
  logic [1:0] depth;
  int mismatches = 0;
  int num_checks = 0;
  int n;
  int ndisp = 0;

  // Free-running instruction clock
  initial
  begin
    forever #2 ref_clk_i = ~ref_clk_i;
  end

  tlip_irq_ctrl uut (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .paddr_i(paddr), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .ext_line_i(ext), .port_change_i(chg),
    .timer_ovf_i(tmr), .periph_evt_i(pev), .instr_boundary_i(bnd),
    .return_from_service_instr_i(ret), .dispatch_o(disp), .vector_o(vec),
    .hi_service_o(hi), .lo_service_o(lo));

  tlip_core_model core (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .ret_go_i(ret_go),
    .dispatch_i(disp), .vector_i(vec), .instr_boundary_o(bnd), .ret_o(ret),
    .depth_o(depth), .pc_o(pc));

  // Counts every dispatch so silent windows can be judged
  always @(posedge ref_clk_i)
  begin
    if (disp === 1'b1)
      ndisp++;
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Setup then access; request held until pready seen high; single word writes
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk_i);
    penable <= 1'b1;
    do @(posedge ref_clk_i); while (pready !== 1'b1);
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk("prdata", e, rd);
  endtask

  // Waits for one dispatch, or a quiet window when none is due
  task automatic wdisp(input logic [15:0] e);
    n = 0;
    while (disp !== 1'b1 && n < 12)
    begin
      @(posedge ref_clk_i);
      #1;
      n++;
    end
    if (e == 16'h0000)
      chk("dispatch", 32'h0000_0000, {31'h0, disp});
    else
      chk("vector", {15'h0, 1'b1, e}, {15'h0, disp, vec});
  endtask

  task automatic rt();
    @(posedge ref_clk_i);
    ret_go <= 1'b1;
    @(posedge ref_clk_i);
    ret_go <= 1'b0;
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Watchdog sized well above the whole sequence
  initial
  begin
    #80000;
    mismatches++;
    end_of_test();
  end

  initial
  begin
    repeat (20) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    rdc(tlip_pkg::CTRL0_OFF, 32'h0000_0000);
    rdc(tlip_pkg::CTRL2_OFF, 32'h0000_0075);
    rdc(tlip_pkg::CTRL3_OFF, 32'h0000_00C0);
    rdc(tlip_pkg::RSTCTL_OFF, 32'h0000_0000);
    for (int g = 0; g < 3; g++)
    begin
      rdc(12'(tlip_pkg::PFLAG1_OFF + tlip_pkg::REG_STRIDE * g), 32'h0000_0000);
      rdc(12'(tlip_pkg::PEN1_OFF + tlip_pkg::REG_STRIDE * g), 32'h0000_0000);
      rdc(12'(tlip_pkg::PPRI1_OFF + tlip_pkg::REG_STRIDE * g), 32'h0000_00FF);
    end
    rdc(12'h034, 32'h0000_0000);
    chk("pslverr", 32'h0000_0001, {31'h0, serr});
    $display("test reset values done");
    // Events with every enable off still set flags
    @(posedge ref_clk_i);
    pev[11] <= 1'b1;
    tmr <= 1'b1;
    ext[1] <= 1'b1;
    chg <= 1'b1;
    @(posedge ref_clk_i);
    pev[11] <= 1'b0;
    tmr <= 1'b0;
    repeat (6) @(posedge ref_clk_i);
    rdc(12'h010, 32'h0000_0008);
    rdc(tlip_pkg::CTRL3_OFF, 32'h0000_00C1);
    rdc(tlip_pkg::CTRL0_OFF, 32'h0000_0005);
    chk("ndisp", 32'h0000_0000, 32'(ndisp));
    apb(1'b1, 12'h010, 32'h0000_0000);
    apb(1'b1, tlip_pkg::CTRL3_OFF, 32'h0000_00C0);
    apb(1'b1, tlip_pkg::CTRL0_OFF, 32'h0000_0000);
    $display("test polling flags done");
    // Compatibility mode: peripheral gate, single vector
    apb(1'b1, tlip_pkg::PPRI1_OFF, 32'h0000_0000);
    apb(1'b1, tlip_pkg::PEN1_OFF, 32'h0000_0001);
    apb(1'b1, tlip_pkg::CTRL0_OFF, 32'h0000_0080);
    @(posedge ref_clk_i);
    pev[0] <= 1'b1;
    @(posedge ref_clk_i);
    pev[0] <= 1'b0;
    wdisp(16'h0000);
    apb(1'b1, tlip_pkg::CTRL0_OFF, 32'h0000_00C0);
    wdisp(tlip_pkg::HI_VEC);
    rdc(tlip_pkg::CTRL0_OFF, 32'h0000_0040);
    apb(1'b1, tlip_pkg::PFLAG1_OFF, 32'h0000_0000);
    rt();
    repeat (4) @(posedge ref_clk_i);
    rdc(tlip_pkg::CTRL0_OFF, 32'h0000_00C0);
    chk("depth", 32'h0000_0000, {30'h0, depth});
    apb(1'b1, tlip_pkg::PEN1_OFF, 32'h0000_0000);
    apb(1'b1, tlip_pkg::CTRL0_OFF, 32'h0000_0090);
    @(posedge ref_clk_i);
    ext[0] <= 1'b1;
    wdisp(tlip_pkg::HI_VEC);
    chk("latency", 32'h0000_0001, {31'h0, n >= 3 && n <= 4});
    apb(1'b1, tlip_pkg::CTRL0_OFF, 32'h0000_0010);
    rt();
    @(posedge ref_clk_i);
    ext[0] <= 1'b0;
    apb(1'b1, tlip_pkg::CTRL0_OFF, 32'h0000_0000);
    $display("test compatibility mode done");
    // Priority mode: low entry, high preemption, low held off
    apb(1'b1, tlip_pkg::RSTCTL_OFF, 32'h0000_0080);
    apb(1'b1, tlip_pkg::CTRL2_OFF, 32'h0000_0071);
    apb(1'b1, tlip_pkg::CTRL0_OFF, 32'h0000_00F0);
    @(posedge ref_clk_i);
    tmr <= 1'b1;
    @(posedge ref_clk_i);
    tmr <= 1'b0;
    wdisp(tlip_pkg::LO_VEC);
    rdc(tlip_pkg::CTRL0_OFF, 32'h0000_00B4);
    apb(1'b1, tlip_pkg::CTRL0_OFF, 32'h0000_00B0);
    @(posedge ref_clk_i);
    ext[0] <= 1'b1;
    wdisp(tlip_pkg::HI_VEC);
    // Core stacks and jumps one edge after the dispatch strobe
    @(posedge ref_clk_i);
    #1;
    chk("service", 32'h0000_0003, {30'h0, hi, lo});
    chk("depth", 32'h0000_0002, {30'h0, depth});
    chk("pc", {16'h0, tlip_pkg::HI_VEC}, {16'h0, pc});
    rdc(tlip_pkg::CTRL0_OFF, 32'h0000_0032);
    apb(1'b1, tlip_pkg::CTRL0_OFF, 32'h0000_00F0);
    @(posedge ref_clk_i);
    tmr <= 1'b1;
    @(posedge ref_clk_i);
    tmr <= 1'b0;
    wdisp(16'h0000);
    rt();
    rt();
    wdisp(tlip_pkg::LO_VEC);
    $display("test priority mode done");
    end_of_test();
  end
endmodule

`default_nettype wire
